/* File: rtl/qsf_params.svh */
`ifndef QSF_PARAMS_SVH
`define QSF_PARAMS_SVH
// ----------------------------------------------------------------
// Opcodes seen by the front end
// ----------------------------------------------------------------
`define QSF_OP_DUAL_OUT   8'h3B
`define QSF_OP_DUAL_IO    8'hBB
`define QSF_OP_QUAD_OUT   8'h6B
`define QSF_OP_QUAD_IO    8'hEB
`define QSF_OP_ENTER_4L   8'h38
`define QSF_OP_EXIT_4L    8'hFF
`define QSF_OP_RST_EN     8'h66
`define QSF_OP_RST_DO     8'h99
// ----------------------------------------------------------------
// Timing and buffer depth
// ----------------------------------------------------------------
`define QSF_CLK_NS        4
`define QSF_SWRST_NS      30000
`define QSF_SWRST_CYC     (`QSF_SWRST_NS / `QSF_CLK_NS)
`define QSF_HWRST_NS      1000
`define QSF_HWRST_CYC     ((`QSF_HWRST_NS + `QSF_CLK_NS - 1) / `QSF_CLK_NS)
`define QSF_FIFO_DEPTH    32
`endif

/* File: rtl/qsf_pkg.sv */
package qsf_pkg;
    // Lane width of the current transfer phase
    typedef enum logic [1:0] {
        QSF_W1,
        QSF_W2,
        QSF_W4
    } qsf_width_type;
    // Front end sequencing
    typedef enum logic [1:0] {
        QSF_IDLE,
        QSF_OPCODE,
        QSF_DATA,
        QSF_SKIP
    } qsf_state_type;
endpackage

/* File: rtl/qsf_fifo.sv */
`timescale 1ns/10ps
// Read data buffer between the array side and the lane shifter
module qsf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,       // System clock
    input  wire logic             rst_n,     // Async reset, active low
    input  wire logic             flush,     // Drop all contents
    input  wire logic [WIDTH-1:0] in_data,   // Fill data
    input  wire logic             in_valid,  // Fill strobe
    output logic                  in_ready,  // Room available
    output logic      [WIDTH-1:0] out_data,  // Head word
    output logic                  out_valid, // Head present
    input  wire logic             out_ready  // Drain strobe
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              do_wr = in_valid && in_ready;
    wire              do_rd = out_valid && out_ready;
    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    // Storage carries no reset, only the pointers do
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
    // Pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) wr_ptr <= wr_ptr + 1'b1;
            if (do_rd) rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

/* File: rtl/qsf_front_end.sv */
// Contract
// [R01] Select high: deselected, all lanes released
// [R02] Ignore instructions until first select fall
// [R03] Single lane: sample input on rising clock
// [R04] Single lane: output changes on falling clock
// [R05] Dual/quad: sample rising, drive falling
// [R06] Quad needs quad enable; pins become lanes
// [R07] Write protect active low, off with quad
// [R08] Pause: output released, input/clock ignored
// [R09] Pause starts at pin fall or clock fall
// [R10] Pause ends at pin rise or clock fall
// [R11] Pause only without quad enable
// [R12] Host keeps select low during pause
// [R13] Accept bus modes 0 and 3
// [R14] 3Bh/BBh use lanes 0 and 1
// [R15] 6Bh/EBh use all four lanes
// [R16] 38h enters, FFh leaves four-lane mode
// [R17] Opcode: two clocks four-lane, eight single
// [R18] Reset and 99h return to single lane
// [R19] Four-lane entry only with quad enable
// [R20] Lane 3 pause or reset by select bit
// [R21] Dedicated reset pin works regardless
// [R22] Select bit 0 pause, 1 reset
// [R23] 66h then 99h resets, busy 30us
// [R24] Reset low 1us returns to power-on state
// [R25] Select fall restarts opcode, rise abandons
`timescale 1ns/10ps
`include "qsf_params.svh"
module qsf_front_end #(
    parameter int SWRST_CYC = `QSF_SWRST_CYC
) (
    input  wire logic       clk,            // System clock, 250 MHz
    input  wire logic       rst_n,          // Async reset, active low
    input  wire logic       chip_sel_n,     // Chip select pin
    input  wire logic       sclk,           // Serial clock pin
    input  wire logic [3:0] lane_in,        // Lanes 0..3 as seen at the pins
    output logic      [3:0] lane_out,       // Lane output values
    output logic      [3:0] lane_oe,        // Lane drive enables
    input  wire logic       reset_pin_n,    // Dedicated reset pin
    input  wire logic       quad_enable_bit,// Nonvolatile quad enable
    input  wire logic       lane3_is_reset, // Lane 3 as reset when set
    input  wire logic       status_write_guard, // Protection configuration
    output logic            status_wr_block,// Status writes blocked
    output logic            four_lane_command_mode, // Four-lane mode active
    output logic            paused,         // Pause condition active
    output logic            busy_reset,     // Reset period running
    output logic      [7:0] opcode,         // Last opcode taken
    output logic            opcode_valid,   // One cycle pulse per accepted opcode
    output logic      [7:0] rx_byte,        // Byte after opcode
    output logic            rx_valid,       // One cycle pulse per byte
    input  wire logic [7:0] tx_data,        // Read data to send
    input  wire logic       tx_valid,       // Read data strobe
    output logic            tx_ready        // Read buffer room
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [6:0] s1;
    logic [6:0] s2;
    logic       sclk_d;
    logic       hold_d;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Select and clock come up low: a select already low at release is no edge
            s1 <= 7'h7C;
            s2 <= 7'h7C;
        end else begin
            s1 <= {reset_pin_n, lane_in, sclk, chip_sel_n}; // see [R02]
            s2 <= s1;
        end
    end
    wire       cs_n   = s2[0];
    wire       sck    = s2[1];
    wire [3:0] lanes  = s2[5:2];
    wire       rpin_n = s2[6];
    wire       sck_rise = sck && !sclk_d;
    wire       sck_fall = !sck && sclk_d;
    // Lane 3 as pause or reset only when quad is off
    wire lane3_fn  = !quad_enable_bit && !four_lane_command_mode;
    wire hold_low  = lane3_fn && !lane3_is_reset && !lanes[3]; // see [R11] see [R20] see [R22]
    wire lane3_rst = lane3_fn && lane3_is_reset && !lanes[3];  // see [R20] see [R22]
    wire hw_rst    = !rpin_n || lane3_rst;                    // see [R21]
    // ------------------------------------------------------------
    // Hardware reset filter
    // ------------------------------------------------------------
    logic [8:0] hw_cnt;
    logic       hw_hit;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_cnt <= '0;
            hw_hit <= 1'b0;
        end else if (!hw_rst) begin
            hw_cnt <= '0;
            hw_hit <= 1'b0;
        end else if (hw_cnt != 9'(`QSF_HWRST_CYC)) begin
            hw_cnt <= hw_cnt + 9'h001;
        end else begin
            hw_hit <= 1'b1; // see [R24]
        end
    end
    // Hardware reset blocks commands while low
    wire blocked = hw_rst || busy_reset; // see [R23] see [R24]
    // ------------------------------------------------------------
    // Pause tracking
    // ------------------------------------------------------------
    // Changes when clock low, else at the next clock fall
    wire hold_take = !cs_n && (!sck || sck_fall);           // see [R09] see [R10]
    wire next_paused = cs_n ? 1'b0 : (hold_take ? hold_low : paused); // see [R08]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            hold_d <= 1'b0;
            paused <= 1'b0;
        end else begin
            sclk_d <= sck;
            hold_d <= cs_n;
            paused <= next_paused;
        end
    end
    wire cs_fall = !cs_n && hold_d;
    wire cs_rise = cs_n && !hold_d;
    // Clock edges are dropped while paused
    wire rise = sck_rise && !paused && !cs_n && !blocked; // see [R08] see [R13]
    wire fall = sck_fall && !paused && !cs_n;             // see [R13]
    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    qsf_pkg::qsf_state_type state;
    qsf_pkg::qsf_width_type rx_w;
    qsf_pkg::qsf_width_type tx_w;
    logic       armed;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic       rst_armed;
    logic [15:0] sw_cnt;
    wire [3:0] step = (rx_w == qsf_pkg::QSF_W4) ? 4'h4 :
                      (rx_w == qsf_pkg::QSF_W2) ? 4'h2 : 4'h1; // see [R17]
    wire [7:0] shin = (rx_w == qsf_pkg::QSF_W4) ? {shreg[3:0], lanes} :
                      (rx_w == qsf_pkg::QSF_W2) ? {shreg[5:0], lanes[1:0]} :
                      {shreg[6:0], lanes[0]}; // see [R03] see [R05]
    wire byte_done = rise && (bitcnt + step == 4'h8);
    wire is_dual  = shin == `QSF_OP_DUAL_OUT || shin == `QSF_OP_DUAL_IO;   // see [R14]
    wire is_quad  = shin == `QSF_OP_QUAD_OUT || shin == `QSF_OP_QUAD_IO;   // see [R15]
    wire quad_ok  = quad_enable_bit;                                          // see [R06]
    wire op_end   = byte_done && state == qsf_pkg::QSF_OPCODE;
    // Width of the phase after an opcode
    wire qsf_pkg::qsf_width_type op_w =
        four_lane_command_mode ? qsf_pkg::QSF_W4 :
        is_dual ? qsf_pkg::QSF_W2 : (is_quad ? qsf_pkg::QSF_W4 : qsf_pkg::QSF_W1);
    wire reject = !four_lane_command_mode && is_quad && !quad_ok; // see [R06]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state  <= qsf_pkg::QSF_IDLE;
            armed  <= 1'b0;
            shreg  <= 8'h00;
            bitcnt <= 4'h0;
            rx_w   <= qsf_pkg::QSF_W1;
            tx_w   <= qsf_pkg::QSF_W1;
            opcode <= 8'h00;
            opcode_valid <= 1'b0;
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
            four_lane_command_mode <= 1'b0; // see [R18]
            rst_armed <= 1'b0;
            busy_reset <= 1'b0;
            sw_cnt <= 16'h0000;
        end else begin
            opcode_valid <= 1'b0;
            rx_valid <= 1'b0;
            if (busy_reset) begin
                sw_cnt <= sw_cnt - 16'h0001;
                if (sw_cnt == 16'h0001) busy_reset <= 1'b0;
            end
            if (hw_hit) begin // see [R24]
                state <= qsf_pkg::QSF_IDLE;
                four_lane_command_mode <= 1'b0;
                rst_armed <= 1'b0;
                busy_reset <= 1'b0;
            end else if (cs_n) begin
                armed <= 1'b1; // A real high select level was seen, see [R02]
                state <= qsf_pkg::QSF_IDLE; // see [R01] see [R25]
            end else if (cs_fall) begin
                state  <= armed ? qsf_pkg::QSF_OPCODE : qsf_pkg::QSF_IDLE; // see [R02]
                bitcnt <= 4'h0; // see [R25]
                rx_w   <= four_lane_command_mode ? qsf_pkg::QSF_W4 : qsf_pkg::QSF_W1;
                tx_w   <= four_lane_command_mode ? qsf_pkg::QSF_W4 : qsf_pkg::QSF_W1;
            end else if (rise && state != qsf_pkg::QSF_IDLE
                         && state != qsf_pkg::QSF_SKIP) begin
                shreg  <= shin;
                bitcnt <= byte_done ? 4'h0 : bitcnt + step;
                if (byte_done && state == qsf_pkg::QSF_DATA) begin
                    rx_byte  <= shin;
                    rx_valid <= 1'b1;
                end
                if (op_end) begin
                    opcode <= shin;
                    opcode_valid <= !reject;
                    rx_w  <= op_w;
                    tx_w  <= op_w;
                    state <= reject ? qsf_pkg::QSF_SKIP : qsf_pkg::QSF_DATA;
                    rst_armed <= shin == `QSF_OP_RST_EN; // see [R23]
                    if (shin == `QSF_OP_ENTER_4L && quad_ok) four_lane_command_mode <= 1'b1; // see [R16] see [R19]
                    if (shin == `QSF_OP_EXIT_4L) four_lane_command_mode <= 1'b0; // see [R16]
                    if (shin == `QSF_OP_RST_DO && rst_armed) begin
                        four_lane_command_mode <= 1'b0; // see [R18]
                        busy_reset <= 1'b1;             // see [R23]
                        sw_cnt <= 16'(SWRST_CYC);
                    end
                end
            end
            if (cs_rise) state <= qsf_pkg::QSF_IDLE; // see [R25]
        end
    end
    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    logic [7:0] fifo_data;
    logic       fifo_valid;
    logic [7:0] txsh;
    logic [3:0] txcnt;
    wire        load = fall && state == qsf_pkg::QSF_DATA && txcnt == 4'h0 && fifo_valid;
    qsf_fifo #(
        .WIDTH(8),
        .DEPTH(`QSF_FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .flush    (cs_n),
        .in_data  (tx_data),
        .in_valid (tx_valid),
        .in_ready (tx_ready),
        .out_data (fifo_data),
        .out_valid(fifo_valid),
        .out_ready(load)
    );
    wire [3:0] tstep = (tx_w == qsf_pkg::QSF_W4) ? 4'h4 :
                       (tx_w == qsf_pkg::QSF_W2) ? 4'h2 : 4'h1;
    wire [7:0] cur   = load ? fifo_data : txsh;
    wire [3:0] next_out = (tx_w == qsf_pkg::QSF_W4) ? cur[7:4] :
                          (tx_w == qsf_pkg::QSF_W2) ? {2'b00, cur[7:6]} :
                          {2'b00, cur[7], 1'b0};
    wire [3:0] next_oe  = (tx_w == qsf_pkg::QSF_W4) ? 4'hF :
                          (tx_w == qsf_pkg::QSF_W2) ? 4'h3 : 4'h2; // see [R04]
    // Lane values change on clock falls only; drive enables also drop on deselect or pause
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txsh <= 8'h00;
            txcnt <= 4'h0;
            lane_out <= 4'h0;
            lane_oe <= 4'h0;
        end else if (cs_n || state != qsf_pkg::QSF_DATA) begin
            txcnt <= 4'h0;
            lane_oe <= 4'h0; // see [R01]
        end else if (paused) begin
            lane_oe <= 4'h0; // Shifter kept so the byte resumes after pause, see [R08]
        end else if (fall && (load || txcnt != 4'h0)) begin
            lane_out <= next_out;          // see [R05]
            lane_oe  <= next_oe;
            txsh     <= cur << tstep;
            txcnt    <= (txcnt + tstep == 4'h8) ? 4'h0 : txcnt + tstep;
        end
    end
    // Write protect only in non-quad mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_wr_block <= 1'b0;
        end else begin
            status_wr_block <= !quad_enable_bit && !lanes[2] && status_write_guard; // see [R07]
        end
    end
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    deselect_float_a: assert property (@(posedge clk) disable iff (!rst_n)
        s2[0] |=> lane_oe == 4'h0) else $error("lanes driven while deselected"); // see [R01]
    pause_float_a: assert property (@(posedge clk) disable iff (!rst_n)
        paused |=> lane_oe == 4'h0) else $error("lanes driven during pause"); // see [R08]
    quad_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(four_lane_command_mode) |-> quad_enable_bit) else $error("four-lane without enable"); // see [R19]
    pause_quad_a: assert property (@(posedge clk) disable iff (!rst_n)
        quad_enable_bit |-> !next_paused) else $error("pause with quad enable"); // see [R11]
    swreset_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(busy_reset) |-> !four_lane_command_mode && sw_cnt == 16'(SWRST_CYC))
        else $error("software reset start wrong"); // see [R23]
    out_on_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(lane_out) |-> $past(sck_fall)) else $error("output moved off a clock fall"); // see [R04]
    opcode_time_a: assert property (@(posedge clk) disable iff (!rst_n)
        opcode_valid |-> $past(rise)) else $error("opcode not on a rise"); // see [R17]
    wp_quad_a: assert property (@(posedge clk) disable iff (!rst_n)
        quad_enable_bit |=> !status_wr_block) else $error("protect active in quad"); // see [R07]
endmodule

/* File: verification/qsf_host_model.sv */
`timescale 1ns/10ps
// Host controller: select, serial clock and lanes
module qsf_host_model (
    input  wire logic       clk,   // System clock
    output logic            cs_n,  // Select, active low
    output logic            sclk,  // Serial clock
    output logic      [3:0] hval,  // Lane values driven
    output logic      [3:0] hoe,   // Lane drive enables
    input  wire logic [3:0] lanes  // Resolved lane levels
);
    logic idle = 1'b0; // Clock idle level, 1 for bus mode 3

    // Select starts low so the first fall is still owed
    initial begin
        cs_n = 1'b0;
        sclk = 1'b0;
        hval = 4'hC;
        hoe  = 4'hD;
    end
    task automatic half();
        repeat (6) @(negedge clk);
    endtask
    task automatic sel();
        @(negedge clk);
        sclk = idle;
        half();
        cs_n = 1'b0;
        half();
    endtask
    task automatic desel();
        @(negedge clk);
        sclk = idle;
        half();
        cs_n = 1'b1;
        hval = 4'hC;
        hoe  = 4'hD;
        half();
    endtask
    // One byte MSB first, w lanes a clock; bits move only while clock is low
    task automatic shift(input int w, input logic [7:0] d, input logic drv,
                         output logic [7:0] q);
        logic [7:0] sh;
        sh = d;
        q = 8'h00;
        for (int i = 0; i < 8 / w; i++) begin
            @(negedge clk);
            sclk = 1'b0;
            case (w)
                1: hval[0] = sh[7];
                2: hval[1:0] = sh[7:6];
                default: hval = sh[7:4];
            endcase
            hoe = (w == 1) ? 4'hD : drv ? 4'hF : (w == 2) ? 4'hC : 4'h0;
            sh = sh << w;
            half();
            sclk = 1'b1;
            q = (w == 1) ? {q[6:0], lanes[1]} :
                (w == 2) ? {q[5:0], lanes[1:0]} : {q[3:0], lanes};
            half();
        end
    endtask
    task automatic pin(input int i, input logic v);
        @(negedge clk);
        hval[i] = v;
    endtask
endmodule

/* File: verification/qsf_front_end_tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module qsf_front_end_tb;
    localparam int SW = 200; // Software reset length in cycles
    logic       clk = 1'b0, rst_n = 1'b0, reset_pin_n = 1'b1, qe = 1'b0, l3r = 1'b0;
    logic       guard = 1'b0, tx_valid = 1'b0, cs_n, sclk, wr_blk, four, paused;
    logic       busy, opv, rxv, tx_ready;
    logic [3:0] hval, hoe, lane_in, lane_out, lane_oe, last_lane = 4'h0;
    logic [7:0] opcode, rx_byte, tx_data = 8'h00, q;
    int         fail_count = 0, total_checks = 0, ov = 0, cyc = 0, b;

    // Device wins the wire; a lane nobody drives shows its last level inverted
    assign lane_in = (lane_oe & lane_out) | (~lane_oe & hoe & hval) | (~lane_oe & ~hoe & ~last_lane);
    initial begin
        forever #2 clk = ~clk;
    end
    // Opcode pulse counter, lane history and run ceiling
    always @(posedge clk) begin
        last_lane <= lane_in;
        if (opv === 1'b1) ov <= ov + 1;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            summarize();
        end
    end
    qsf_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .hval(hval), .hoe(hoe),
                         .lanes(lane_in));
    qsf_front_end #(.SWRST_CYC(SW)) dut (
        .clk(clk), .rst_n(rst_n), .chip_sel_n(cs_n), .sclk(sclk), .lane_in(lane_in),
        .lane_out(lane_out), .lane_oe(lane_oe), .reset_pin_n(reset_pin_n),
        .quad_enable_bit(qe), .lane3_is_reset(l3r), .status_write_guard(guard),
        .status_wr_block(wr_blk), .four_lane_command_mode(four), .paused(paused),
        .busy_reset(busy), .opcode(opcode), .opcode_valid(opv), .rx_byte(rx_byte),
        .rx_valid(rxv), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

    task automatic waitc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Wait up to 50 cycles for room, then offer one word; an edge passes before the next offer
    task automatic push(input logic [7:0] d);
        for (int k = 0; k < 50 && tx_ready !== 1'b1; k++) @(negedge clk);
        tx_data = d;
        tx_valid = 1'b1;
        @(negedge clk);
        tx_valid = 1'b0;
        @(negedge clk);
    endtask
    task automatic cmd(input int w, input logic [7:0] op);
        host.sel();
        host.shift(w, op, 1'b1, q);
        host.desel();
    endtask
    task automatic t_power();
        host.shift(1, 8'h05, 1'b1, q);
        `CHK(ov, 0)
        host.desel();
        cmd(1, 8'h05);
        `CHK(ov, 1)
        `CHK(opcode, 8'h05)
        host.sel();
        host.shift(2, 8'hFF, 1'b1, q); // Half an opcode, then deselect
        host.desel();
        host.idle = 1'b1;
        cmd(1, 8'h5A);
        host.idle = 1'b0;
        `CHK(ov, 2)
        `CHK(opcode, 8'h5A)
    endtask
    // The buffer is flushed while deselected, so it is filled inside the frame
    task automatic t_fifo();
        qe = 1'b1;
        host.sel();
        for (int k = 0; k < 32; k++) push(8'(k));
        `CHK(tx_ready, 1'b0)
        host.shift(1, 8'h6B, 1'b1, q);
        for (int k = 0; k < 32; k++) begin
            host.shift(4, 8'h00, 1'b0, q);
            `CHK(q, 8'(k))
        end
        host.desel();
        qe = 1'b0;
        `CHK(tx_ready, 1'b1)
    endtask
    // Read at w lanes; the byte taken in is the host's in single, the echo otherwise
    task automatic t_dual(input logic [7:0] op, input int w, input logic [3:0] oe);
        host.sel();
        push(op ^ 8'h96);
        host.shift(1, op, 1'b1, q);
        host.shift(w, ~op, 1'b0, q);
        `CHK(q, op ^ 8'h96)
        `CHK(lane_oe, oe)
        `CHK(rx_byte, (w == 1) ? ~op : op ^ 8'h96)
        host.desel();
        `CHK(lane_oe, 4'h0)
    endtask
    task automatic t_quad();
        b = ov;
        cmd(1, 8'h6B);
        `CHK(ov, b)
        qe = 1'b1;
        host.sel();
        push(8'h3C);
        host.shift(1, 8'hEB, 1'b1, q);
        host.shift(4, 8'h00, 1'b0, q);
        `CHK(q, 8'h3C)
        `CHK(lane_oe, 4'hF)
        host.desel();
        qe = 1'b0;
    endtask
    task automatic t_mode();
        cmd(1, 8'h38);
        `CHK(four, 1'b0)
        qe = 1'b1;
        cmd(1, 8'h38);
        `CHK(four, 1'b1)
        cmd(4, 8'hFF);
        `CHK(four, 1'b0)
        `CHK(opcode, 8'hFF)
        qe = 1'b0;
    endtask
    task automatic t_swrst();
        qe = 1'b1;
        cmd(1, 8'h38);
        cmd(4, 8'h66);
        cmd(4, 8'h99);
        `CHK(busy, 1'b1)
        `CHK(four, 1'b0)
        qe = 1'b0;
        b = ov;
        cmd(1, 8'h05);
        `CHK(ov, b)
        waitc(SW);
        `CHK(busy, 1'b0)
        cmd(1, 8'h66);
        cmd(1, 8'h05);
        cmd(1, 8'h99);
        `CHK(busy, 1'b0)
    endtask
    task automatic t_pause();
        host.sel();
        host.pin(3, 1'b0);
        waitc(10);
        `CHK(paused, 1'b1)
        host.shift(1, 8'h00, 1'b1, q); // Select stays low
        host.pin(3, 1'b1);
        waitc(10);
        `CHK(paused, 1'b1)
        b = ov;
        host.shift(1, 8'h5A, 1'b1, q);
        host.desel();
        `CHK(ov, b + 1)
        `CHK(opcode, 8'h5A)
        qe = 1'b1;
        host.sel();
        host.pin(3, 1'b0);
        waitc(10);
        `CHK(paused, 1'b0)
        host.pin(3, 1'b1);
        host.desel();
        qe = 1'b0;
    endtask
    task automatic t_wp();
        for (int i = 0; i < 8; i++) begin
            guard = i[0];
            qe = i[2];
            host.pin(2, i[1]);
            waitc(6);
            `CHK(wr_blk, i[0] & ~i[1] & ~i[2])
        end
        host.pin(2, 1'b1);
        qe = 1'b0;
        guard = 1'b0;
    endtask
    task automatic t_reset();
        qe = 1'b1;
        cmd(1, 8'h38);
        reset_pin_n = 1'b0;
        waitc(260); // Longer than the 1 us minimum
        reset_pin_n = 1'b1;
        waitc(10);
        `CHK(four, 1'b0)
        qe = 1'b0;
        l3r = 1'b1;
        host.pin(3, 1'b0);
        waitc(260);
        b = ov;
        cmd(1, 8'h05);
        `CHK(ov, b)
        `CHK(paused, 1'b0)
        host.pin(3, 1'b1);
        waitc(10);
        l3r = 1'b0;
    endtask
    task automatic summarize();
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Reset for four cycles, then each scenario in turn
    initial begin
        waitc(4);
        rst_n = 1'b1;
        waitc(4);
        t_power();
        t_fifo();
        t_dual(8'h0B, 1, 4'h2);
        t_dual(8'h3B, 2, 4'h3);
        t_dual(8'hBB, 2, 4'h3);
        t_quad();
        t_mode();
        t_swrst();
        t_pause();
        t_wp();
        t_reset();
        summarize();
    end
endmodule
